// file: serial_link_param_pkg.sv
/*
 * Constants for the serial link parameter register bank: register offsets,
 * field positions, reset values and link defaults.
 * Assumes a 7-bit address space of 8-bit registers reached through the serial control port.
 */
package serial_link_param_pkg;

	// Register offsets
	localparam logic [6:0] OFS_LINK_PARAM_OVERRIDE_CTRL = 7'h27;
	localparam logic [6:0] OFS_SCRAMBLER_CTRL           = 7'h2B;
	localparam logic [6:0] OFS_FRAME_OCTETS_CFG         = 7'h2C;
	localparam logic [6:0] OFS_MULTIFRAME_FRAMES_CFG    = 7'h2D;
	localparam logic [6:0] OFS_LINK_SUBCLASS_CFG        = 7'h30;
	localparam logic [6:0] OFS_SYNC_LMFC_DRIVE_CTRL     = 7'h36;

	// Writable bits of each register; all others are reserved and read zero
	localparam logic [7:0] MASK_LINK_PARAM_OVERRIDE_CTRL = 8'h03;
	localparam logic [7:0] MASK_SCRAMBLER_CTRL           = 8'h80;
	localparam logic [7:0] MASK_FRAME_OCTETS_CFG         = 8'h01;
	localparam logic [7:0] MASK_MULTIFRAME_FRAMES_CFG    = 8'h1F;
	localparam logic [7:0] MASK_LINK_SUBCLASS_CFG        = 8'hE0;
	localparam logic [7:0] MASK_SYNC_LMFC_DRIVE_CTRL     = 8'hCF;

	// Reset values
	localparam logic [7:0] RST_LINK_PARAM_OVERRIDE_CTRL = 8'h00;
	localparam logic [7:0] RST_SCRAMBLER_CTRL           = 8'h00;
	localparam logic [7:0] RST_FRAME_OCTETS_CFG         = 8'h00;
	localparam logic [7:0] RST_MULTIFRAME_FRAMES_CFG    = 8'h00;
	localparam logic [7:0] RST_LINK_SUBCLASS_CFG        = 8'h40;
	localparam logic [7:0] RST_SYNC_LMFC_DRIVE_CTRL     = 8'h00;

	// Field positions
	localparam int BIT_CTRL_F          = 0;
	localparam int BIT_CTRL_K          = 1;
	localparam int BIT_SCRAMBLE_EN     = 7;
	localparam int BIT_OCTETS_PER_FRM  = 0;
	localparam int POS_K_LSB           = 0;
	localparam int POS_SUBCLASS_LSB    = 5;
	localparam int BIT_SYNC_REQ        = 7;
	localparam int BIT_LMFC_RST_IGNORE = 6;
	localparam int POS_DRIVE_LSB       = 0;

	// Lane modes and link defaults
	typedef enum logic {LANE_TWO_PER_CONV = 1'b0, LANE_ONE_PER_CONV = 1'b1} lane_mode_t;
	localparam logic [4:0] K_DEFAULT_TWO_LANE = 5'h10;
	localparam logic [4:0] K_DEFAULT_ONE_LANE = 5'h08;
	localparam logic [1:0] F_TWO_LANE         = 2'h1;
	localparam logic [1:0] F_ONE_LANE         = 2'h2;

	// Subclass codes
	localparam logic [2:0] SUBCLASS_0 = 3'h0;
	localparam logic [2:0] SUBCLASS_1 = 3'h1;
	localparam logic [2:0] SUBCLASS_2 = 3'h2;

	// Serial control word: read flag, 7-bit address, 8-bit data
	localparam int          SPI_WORD_BITS = 16;
	localparam int          SPI_CMD_BITS  = 8;
	localparam logic [4:0]  SPI_CMD_LAST  = 5'h07;
	localparam logic [4:0]  SPI_WORD_LAST = 5'h0F;
	localparam logic [4:0]  SPI_DONE      = 5'h10;

	// Scrambler polynomial 1 + x^14 + x^15
	localparam int SCR_LEN = 15;
	localparam int SCR_TAP = 14;

endpackage

// file: serial_ctrl_port.sv
/*
 * Serial control port slave: 16-bit words, MSB first, sampled on the rising
 * serial clock edge; first bit high means read, then 7 address bits, then data.
 * Assumes the serial pins are synchronous to core_clk and change slower than it.
 */
`timescale 1ns/1ps
module serial_ctrl_port
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Serial pins
	input  wire logic       serEnN,
	input  wire logic       serClk,
	input  wire logic       serDataIn,
	output logic            serDataOut,
	output logic            serDataOutEn,
	// Register access
	output logic [6:0]      regAddr,
	output logic [7:0]      regWrData,
	output logic            regWrStrobe,
	input  wire logic [7:0] regRdData
);
	import serial_link_param_pkg::*;

	logic [15:0] shiftIn_reg, shiftIn_next;
	logic [7:0]  shiftOut_reg, shiftOut_next;
	logic [4:0]  bitCnt_reg, bitCnt_next;
	logic        isRead_reg, isRead_next;
	logic [6:0]  addr_reg, addr_next;
	logic [7:0]  wrData_reg, wrData_next;
	logic        wrStrobe_reg, wrStrobe_next;
	logic        sclkPrev_reg;
	logic        sclkRise;
	logic        sclkFall;

	assign sclkRise = serClk & ~sclkPrev_reg;
	assign sclkFall = ~serClk & sclkPrev_reg;

	always_comb
	begin
		shiftIn_next  = shiftIn_reg;
		shiftOut_next = shiftOut_reg;
		bitCnt_next   = bitCnt_reg;
		isRead_next   = isRead_reg;
		addr_next     = addr_reg;
		wrData_next   = wrData_reg;
		wrStrobe_next = 1'b0;
		if (serEnN)
		begin
			bitCnt_next = '0;
			isRead_next = 1'b0;
		end
		else if (sclkRise && bitCnt_reg != SPI_DONE)
		begin
			shiftIn_next = {shiftIn_reg[14:0], serDataIn};
			bitCnt_next  = bitCnt_reg + 5'h01;
			if (bitCnt_reg == SPI_CMD_LAST)
			begin
				isRead_next = shiftIn_reg[6];
				addr_next   = {shiftIn_reg[5:0], serDataIn};
			end
			// Writes commit only on a complete word
			if (bitCnt_reg == SPI_WORD_LAST && !isRead_reg)
			begin
				wrData_next   = {shiftIn_reg[6:0], serDataIn};
				wrStrobe_next = 1'b1;
			end
		end
		else if (sclkFall && isRead_reg)
		begin
			if (bitCnt_reg == SPI_CMD_LAST + 5'h01)
				shiftOut_next = regRdData;
			else
				shiftOut_next = {shiftOut_reg[6:0], 1'b0};
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			shiftIn_reg  <= '0;
			shiftOut_reg <= '0;
			bitCnt_reg   <= '0;
			isRead_reg   <= 1'b0;
			addr_reg     <= '0;
			wrData_reg   <= '0;
			wrStrobe_reg <= 1'b0;
			sclkPrev_reg <= 1'b0;
		end
		else
		begin
			shiftIn_reg  <= shiftIn_next;
			shiftOut_reg <= shiftOut_next;
			bitCnt_reg   <= bitCnt_next;
			isRead_reg   <= isRead_next;
			addr_reg     <= addr_next;
			wrData_reg   <= wrData_next;
			wrStrobe_reg <= wrStrobe_next;
			sclkPrev_reg <= serClk;
		end
	end

	assign serDataOut   = shiftOut_reg[7];
	assign serDataOutEn = isRead_reg & ~serEnN;
	assign regAddr      = addr_reg;
	assign regWrData    = wrData_reg;
	assign regWrStrobe  = wrStrobe_reg;

endmodule // serial_ctrl_port

// file: serial_link_param_regs.sv
/*
 * Serial link parameter register bank with the link logic it steers:
 * frame and multiframe sizing, scrambler, LMFC counter and sync request.
 * Assumes octets arrive one per cycle when valid, and the link sync and
 * system reference inputs are synchronous to core_clk.
 */
// Contract
// - K override bit set uses programmed K, else default K.
// - F override bit set takes F from octets register, else default.
// - Payload is scrambled only while scramble enable is set.
// - Octets-per-frame bit 0 selects two-lane mode, 1 one-lane mode.
// - Default K is 16 in two-lane mode and 8 in one-lane mode.
// - Subclass codes 000, 001, 010 select subclass 0, 1, 2.
// - Software sync-request bit acts as a link synchronization request.
// - LMFC reset ignore bit makes link logic ignore LMFC reset events.
// - F is 1 in two-lane mode and 2 in one-lane mode.
// - System reference event clears LMFC counter unless ignore bit set.
`timescale 1ns/1ps
module serial_link_param_regs
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Serial control port
	input  wire logic       serEnN,
	input  wire logic       serClk,
	input  wire logic       serDataIn,
	output logic            serDataOut,
	output logic            serDataOutEn,
	// Octet stream
	input  wire logic [7:0] octetIn,
	input  wire logic       octetInValid,
	output logic [7:0]      octetOut,
	output logic            octetOutValid,
	// Link timing
	input  wire logic       linkSyncN,
	input  wire logic       sysrefPulse,
	output logic            syncRequest,
	output logic [4:0]      lmfcCount,
	output logic            lmfcBoundary,
	output logic            frameBoundary,
	// Effective configuration
	output serial_link_param_pkg::lane_mode_t laneMode,
	output logic [1:0]      octetsPerFrame,
	output logic [4:0]      framesPerMultiframe,
	output logic            scrambleOn,
	output logic [2:0]      subclass,
	output logic            multiframe_clk_reset_ignore,
	output logic [3:0]      driveCurrentSel
);
	import serial_link_param_pkg::*;

	// Writable bits of the register at an address, zero when unmapped
	function automatic logic [7:0] writeMask(input logic [6:0] addr);
		case (addr)
			OFS_LINK_PARAM_OVERRIDE_CTRL: writeMask = MASK_LINK_PARAM_OVERRIDE_CTRL;
			OFS_SCRAMBLER_CTRL:           writeMask = MASK_SCRAMBLER_CTRL;
			OFS_FRAME_OCTETS_CFG:         writeMask = MASK_FRAME_OCTETS_CFG;
			OFS_MULTIFRAME_FRAMES_CFG:    writeMask = MASK_MULTIFRAME_FRAMES_CFG;
			OFS_LINK_SUBCLASS_CFG:        writeMask = MASK_LINK_SUBCLASS_CFG;
			OFS_SYNC_LMFC_DRIVE_CTRL:     writeMask = MASK_SYNC_LMFC_DRIVE_CTRL;
			default:                      writeMask = 8'h00;
		endcase
	endfunction

	logic [6:0] regAddr;
	logic [7:0] regWrData;
	logic       regWrStrobe;
	logic [7:0] regRdData;
	logic [7:0] wrValue;

	serial_ctrl_port u_ctrl_port
	(
		.core_clk     (core_clk),
		.rst          (rst),
		.serEnN       (serEnN),
		.serClk       (serClk),
		.serDataIn    (serDataIn),
		.serDataOut   (serDataOut),
		.serDataOutEn (serDataOutEn),
		.regAddr      (regAddr),
		.regWrData    (regWrData),
		.regWrStrobe  (regWrStrobe),
		.regRdData    (regRdData)
	);

	// Register bank
	logic [7:0] overrideCtrl_reg, overrideCtrl_next;
	logic [7:0] scramblerCtrl_reg, scramblerCtrl_next;
	logic [7:0] frameOctets_reg, frameOctets_next;
	logic [7:0] multiframeFrames_reg, multiframeFrames_next;
	logic [7:0] subclassCfg_reg, subclassCfg_next;
	logic [7:0] syncLmfcDrive_reg, syncLmfcDrive_next;

	// Reserved bits are dropped on write so they always read zero
	assign wrValue = regWrData & writeMask(regAddr);

	always_comb
	begin
		overrideCtrl_next     = overrideCtrl_reg;
		scramblerCtrl_next    = scramblerCtrl_reg;
		frameOctets_next      = frameOctets_reg;
		multiframeFrames_next = multiframeFrames_reg;
		subclassCfg_next      = subclassCfg_reg;
		syncLmfcDrive_next    = syncLmfcDrive_reg;
		if (regWrStrobe)
		begin
			case (regAddr)
				OFS_LINK_PARAM_OVERRIDE_CTRL: overrideCtrl_next     = wrValue;
				OFS_SCRAMBLER_CTRL:           scramblerCtrl_next    = wrValue;
				OFS_FRAME_OCTETS_CFG:         frameOctets_next      = wrValue;
				OFS_MULTIFRAME_FRAMES_CFG:    multiframeFrames_next = wrValue;
				OFS_LINK_SUBCLASS_CFG:        subclassCfg_next      = wrValue;
				OFS_SYNC_LMFC_DRIVE_CTRL:     syncLmfcDrive_next    = wrValue;
				default:                      ;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			overrideCtrl_reg     <= RST_LINK_PARAM_OVERRIDE_CTRL;
			scramblerCtrl_reg    <= RST_SCRAMBLER_CTRL;
			frameOctets_reg      <= RST_FRAME_OCTETS_CFG;
			multiframeFrames_reg <= RST_MULTIFRAME_FRAMES_CFG;
			subclassCfg_reg      <= RST_LINK_SUBCLASS_CFG;
			syncLmfcDrive_reg    <= RST_SYNC_LMFC_DRIVE_CTRL;
		end
		else
		begin
			overrideCtrl_reg     <= overrideCtrl_next;
			scramblerCtrl_reg    <= scramblerCtrl_next;
			frameOctets_reg      <= frameOctets_next;
			multiframeFrames_reg <= multiframeFrames_next;
			subclassCfg_reg      <= subclassCfg_next;
			syncLmfcDrive_reg    <= syncLmfcDrive_next;
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		case (regAddr)
			OFS_LINK_PARAM_OVERRIDE_CTRL: regRdData = overrideCtrl_reg;
			OFS_SCRAMBLER_CTRL:           regRdData = scramblerCtrl_reg;
			OFS_FRAME_OCTETS_CFG:         regRdData = frameOctets_reg;
			OFS_MULTIFRAME_FRAMES_CFG:    regRdData = multiframeFrames_reg;
			OFS_LINK_SUBCLASS_CFG:        regRdData = subclassCfg_reg;
			OFS_SYNC_LMFC_DRIVE_CTRL:     regRdData = syncLmfcDrive_reg;
			default:                      regRdData = 8'h00;
		endcase
	end

	// Effective link parameters
	always_comb
	begin
		// F override selects the programmed lane mode
		// octets bit picks the lane mode
		if (overrideCtrl_reg[BIT_CTRL_F])
			laneMode = lane_mode_t'(frameOctets_reg[BIT_OCTETS_PER_FRM]);
		else
			laneMode = LANE_TWO_PER_CONV;
		// octets per frame from lane mode
		octetsPerFrame = (laneMode == LANE_ONE_PER_CONV) ? F_ONE_LANE : F_TWO_LANE;
		if (overrideCtrl_reg[BIT_CTRL_K])
			framesPerMultiframe = multiframeFrames_reg[POS_K_LSB +: 5];
		else if (laneMode == LANE_ONE_PER_CONV)
			framesPerMultiframe = K_DEFAULT_ONE_LANE;
		else
			framesPerMultiframe = K_DEFAULT_TWO_LANE;
	end

	// subclass code straight from the field
	assign subclass                    = subclassCfg_reg[POS_SUBCLASS_LSB +: 3];
	assign scrambleOn                  = scramblerCtrl_reg[BIT_SCRAMBLE_EN];
	assign multiframe_clk_reset_ignore = syncLmfcDrive_reg[BIT_LMFC_RST_IGNORE];
	assign driveCurrentSel             = syncLmfcDrive_reg[POS_DRIVE_LSB +: 4];
	// software bit merged with the link request
	assign syncRequest                 = syncLmfcDrive_reg[BIT_SYNC_REQ] | ~linkSyncN;

	// Frame and multiframe counters
	logic       octetPos_reg, octetPos_next;
	logic [4:0] lmfcCount_reg, lmfcCount_next;
	logic       frameEnd_reg, frameEnd_next;
	logic       lmfcWrap_reg, lmfcWrap_next;
	logic       frameLast;

	assign frameLast = (octetsPerFrame == F_TWO_LANE) | octetPos_reg;

	always_comb
	begin
		octetPos_next  = octetPos_reg;
		lmfcCount_next = lmfcCount_reg;
		frameEnd_next  = 1'b0;
		lmfcWrap_next  = 1'b0;
		if (octetInValid)
		begin
			octetPos_next = ~frameLast;
			if (frameLast)
			begin
				frameEnd_next = 1'b1;
				// Wrap after count K - 1, so K frames per multiframe; K of zero or one is never programmed
				// K range kept by software
				if (lmfcCount_reg >= framesPerMultiframe - 5'h01)
				begin
					lmfcCount_next = '0;
					lmfcWrap_next  = 1'b1;
				end
				else
					lmfcCount_next = lmfcCount_reg + 5'h01;
			end
		end
		if (sysrefPulse && !multiframe_clk_reset_ignore)
		begin
			lmfcCount_next = '0;
			octetPos_next  = 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			octetPos_reg  <= 1'b0;
			lmfcCount_reg <= '0;
			frameEnd_reg  <= 1'b0;
			lmfcWrap_reg  <= 1'b0;
		end
		else
		begin
			octetPos_reg  <= octetPos_next;
			lmfcCount_reg <= lmfcCount_next;
			frameEnd_reg  <= frameEnd_next;
			lmfcWrap_reg  <= lmfcWrap_next;
		end
	end

	assign lmfcCount     = lmfcCount_reg;
	assign frameBoundary = frameEnd_reg;
	assign lmfcBoundary  = lmfcWrap_reg;

	// Self-synchronous scrambler, MSB of each octet first
	logic [SCR_LEN-1:0] scrState_reg, scrState_next;
	logic [7:0]         octetOut_reg, octetOut_next;
	logic               octetOutValid_reg, octetOutValid_next;

	always_comb
	begin
		logic [SCR_LEN-1:0] st;
		logic [7:0]         scr;
		logic               b;
		st  = scrState_reg;
		scr = '0;
		b   = 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			b      = octetIn[i] ^ st[SCR_TAP-1] ^ st[SCR_LEN-1];
			scr[i] = b;
			st     = {st[SCR_LEN-2:0], b};
		end
		scrState_next      = scrState_reg;
		octetOut_next      = octetOut_reg;
		octetOutValid_next = octetInValid;
		if (octetInValid)
		begin
			if (scrambleOn)
			begin
				octetOut_next = scr;
				scrState_next = st;
			end
			else
			begin
				octetOut_next = octetIn;
				scrState_next = '0;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			scrState_reg      <= '0;
			octetOut_reg      <= '0;
			octetOutValid_reg <= 1'b0;
		end
		else
		begin
			scrState_reg      <= scrState_next;
			octetOut_reg      <= octetOut_next;
			octetOutValid_reg <= octetOutValid_next;
		end
	end

	assign octetOut      = octetOut_reg;
	assign octetOutValid = octetOutValid_reg;

endmodule // serial_link_param_regs

// file: serial_link_param_props.sv
/* Checker for serial_link_param_regs: timing relations of the link logic.
   Assumes it is bound to the ports of the top module. */
`timescale 1ns/1ps
module serial_link_param_props
(
	// Clock and reset
	input wire logic       core_clk,
	input wire logic       rst,
	// Octet stream
	input wire logic [7:0] octetIn,
	input wire logic       octetInValid,
	input wire logic [7:0] octetOut,
	input wire logic       octetOutValid,
	// Link timing
	input wire logic       linkSyncN,
	input wire logic       sysrefPulse,
	input wire logic       syncRequest,
	input wire logic [4:0] lmfcCount,
	input wire logic       lmfcBoundary,
	input wire logic       frameBoundary,
	// Configuration
	input wire serial_link_param_pkg::lane_mode_t laneMode,
	input wire logic [1:0] octetsPerFrame,
	input wire logic [4:0] framesPerMultiframe,
	input wire logic       scrambleOn,
	input wire logic [2:0] subclass,
	input wire logic       multiframe_clk_reset_ignore
);
	import serial_link_param_pkg::*;
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (rst);
	a_reset_subclass: assert property ($fell(rst) |-> subclass == 3'h2)
		else $error("subclass not 2 after reset");
	a_reset_frames: assert property ($fell(rst) |-> framesPerMultiframe == 5'h10)
		else $error("K not 16 after reset");
	a_frame_octets: assert property (octetsPerFrame == (laneMode == LANE_ONE_PER_CONV ? 2'h2 : 2'h1))
		else $error("F does not follow lane mode");
	a_sync_follow: assert property (!linkSyncN |-> syncRequest)
		else $error("sync request lost");
	a_plain_octets: assert property (octetInValid && !scrambleOn |=> octetOutValid && octetOut == $past(octetIn))
		else $error("unscrambled octet altered");
	a_sysref_clear: assert property (sysrefPulse && !multiframe_clk_reset_ignore |=> lmfcCount == 5'h00)
		else $error("reference event did not clear count");
	a_sysref_ignored: assert property (sysrefPulse && multiframe_clk_reset_ignore && !octetInValid |=> $stable(lmfcCount))
		else $error("masked reference event moved count");
	a_wrap_zero: assert property (lmfcBoundary |-> lmfcCount == 5'h00)
		else $error("boundary without wrap");
	a_frame_cause: assert property (frameBoundary |-> $past(octetInValid))
		else $error("frame boundary without octet");
endmodule // serial_link_param_props

// file: link_rx_model.sv
/* Link receiver stand-in: drives sync request and reference events, counts frames.
   Assumes bench requests change at falling edges. */
`timescale 1ns/1ps
module link_rx_model
(
	// Clock
	input  wire logic core_clk,
	// Bench control
	input  wire logic holdSync,
	input  wire logic sysrefReq,
	// Link side
	input  wire logic frameBoundary,
	output logic      linkSyncN,
	output logic      sysrefPulse,
	output int        frameCount
);
	logic reqLast;
	initial
	begin
		linkSyncN = 1'b1;
		sysrefPulse = 1'b0;
		reqLast = 1'b0;
		frameCount = 0;
	end
	// One-cycle event per request; requests are taken where they are settled
	always @(posedge core_clk)
	begin
		linkSyncN <= !holdSync;
		sysrefPulse <= sysrefReq && !reqLast;
		reqLast <= sysrefReq;
	end
	always @(posedge core_clk)
		if (frameBoundary)
			frameCount <= frameCount + 1;
endmodule // link_rx_model

// file: serial_link_param_regs_tb_top.sv
/* Bench for serial_link_param_regs: serial register access, octet stream, link events.
   Assumes link_rx_model at the far side. */
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module serial_link_param_regs_tb_top;
	import serial_link_param_pkg::*;
	logic       core_clk, rst, serEnN, serClk, serDataIn, serDataOut, serDataOutEn;
	logic [7:0] octetIn, octetOut, rdData;
	logic       octetInValid, octetOutValid, linkSyncN, sysrefPulse, syncRequest;
	logic       lmfcBoundary, frameBoundary, scrambleOn, multiframe_clk_reset_ignore;
	logic [4:0] lmfcCount, framesPerMultiframe;
	logic [1:0] octetsPerFrame;
	logic [2:0] subclass;
	logic [3:0] driveCurrentSel;
	logic       holdSync, sysrefReq;
	lane_mode_t laneMode;
	int         frameCount, n, f0;
	int         oeBad = 0;
	int         wraps = 0;
	int         err_total = 0;
	int         compares = 0;

	serial_link_param_regs serial_link_param_regs_inst (.core_clk, .rst, .serEnN, .serClk, .serDataIn, .serDataOut,
		.serDataOutEn, .octetIn, .octetInValid, .octetOut, .octetOutValid, .linkSyncN, .sysrefPulse, .syncRequest,
		.lmfcCount, .lmfcBoundary, .frameBoundary, .laneMode, .octetsPerFrame, .framesPerMultiframe, .scrambleOn,
		.subclass, .multiframe_clk_reset_ignore, .driveCurrentSel);
	link_rx_model link_rx_model_inst (.core_clk, .holdSync, .sysrefReq, .frameBoundary, .linkSyncN, .sysrefPulse,
		.frameCount);

	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// Multiframe wraps seen on the boundary pulse
	always @(posedge core_clk)
		if (lmfcBoundary)
			wraps <= wraps + 1;

	task automatic cyc(input int k);
		repeat (k) @(negedge core_clk);
	endtask

	// Serial clock phases last three cycles each
	task automatic spi(input logic rd, input logic [6:0] a, input logic [7:0] d);
		logic [15:0] w;
		w = {rd, a, d};
		rdData = 8'h00;
		serEnN = 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			serClk = 1'b0;
			serDataIn = w[i];
			cyc(3);
			if (i < 8)
			begin
				rdData[i] = serDataOut;
				if (serDataOutEn !== rd)
					oeBad++;
			end
			serClk = 1'b1;
			cyc(3);
		end
		serClk = 1'b0;
		cyc(3);
		serEnN = 1'b1;
		cyc(3);
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		spi(1'b0, a, d);
	endtask

	task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
		spi(1'b1, a, 8'h00);
		`CHK(rdData, e)
	endtask

	// First octet d, then zeros; counts octets that came out altered
	task automatic stream(input int k, input logic [7:0] d, output int diff);
		diff = 0;
		octetInValid = 1'b1;
		for (int i = 0; i < k; i++)
		begin
			octetIn = d;
			cyc(1);
			if (octetOut !== d || octetOutValid !== 1'b1)
				diff++;
			d = 8'h00;
		end
		octetInValid = 1'b0;
		cyc(2);
	endtask

	task automatic sysref;
		sysrefReq = 1'b1;
		cyc(1);
		sysrefReq = 1'b0;
		cyc(3);
	endtask

	task automatic t_reset;
		logic [6:0] ofs [6] = '{7'h27, 7'h2B, 7'h2C, 7'h2D, 7'h30, 7'h36};
		logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00};
		for (int i = 0; i < 6; i++)
			rdchk(ofs[i], rv[i]);
		rdchk(7'h28, 8'h00);
		`CHK(subclass, 3'h2)
		`CHK(framesPerMultiframe, 5'h10)
		`CHK(laneMode, LANE_TWO_PER_CONV)
	endtask

	task automatic t_override;
		wr(7'h2C, 8'h01);
		`CHK(octetsPerFrame, 2'h1)
		wr(7'h27, 8'h01);
		`CHK(laneMode, LANE_ONE_PER_CONV)
		`CHK(octetsPerFrame, 2'h2)
		`CHK(framesPerMultiframe, 5'h08)
		f0 = frameCount;
		stream(4, 8'h5A, n);
		`CHK(n, 0)
		`CHK(frameCount - f0, 2)
		// K kept above the mode default and below 32
		wr(7'h2D, 8'h14);
		`CHK(framesPerMultiframe, 5'h08)
		wr(7'h27, 8'h03);
		`CHK(framesPerMultiframe, 5'h14)
		rdchk(7'h27, 8'h03);
		`CHK(oeBad, 0)
		wr(7'h27, 8'h00);
		wr(7'h2C, 8'h00);
		`CHK(framesPerMultiframe, 5'h10)
	endtask

	task automatic t_subclass;
		for (int c = 0; c < 3; c++)
		begin
			wr(7'h30, 8'(c << 5));
			`CHK(subclass, 3'(c))
		end
		wr(7'h30, 8'h40);
	endtask

	task automatic t_scramble;
		stream(4, 8'hA5, n);
		`CHK(n, 0)
		wr(7'h2B, 8'h80);
		stream(6, 8'hFF, n);
		`CHK(n > 0, 1'b1)
		wr(7'h2B, 8'h00);
		stream(4, 8'h3C, n);
		`CHK(n, 0)
	endtask

	task automatic t_sync_lmfc;
		`CHK(syncRequest, 1'b0)
		wr(7'h36, 8'h8A);
		`CHK(syncRequest, 1'b1)
		`CHK(driveCurrentSel, 4'hA)
		wr(7'h36, 8'h00);
		holdSync = 1'b1;
		cyc(2);
		`CHK(syncRequest, 1'b1)
		holdSync = 1'b0;
		sysref;
		`CHK(lmfcCount, 5'h00)
		stream(3, 8'h11, n);
		`CHK(lmfcCount, 5'h03)
		f0 = wraps;
		stream(16, 8'h22, n);
		`CHK(lmfcCount, 5'h03)
		`CHK(wraps - f0, 1)
		wr(7'h36, 8'h40);
		sysref;
		`CHK(lmfcCount, 5'h03)
		wr(7'h36, 8'h00);
		sysref;
		`CHK(lmfcCount, 5'h00)
	endtask

	task automatic give_verdict;
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		serEnN = 1'b1;
		serClk = 1'b0;
		serDataIn = 1'b0;
		octetIn = 8'h00;
		octetInValid = 1'b0;
		holdSync = 1'b0;
		sysrefReq = 1'b0;
		rst = 1'b1;
		cyc(8);
		rst = 1'b0;
		cyc(2);
		t_reset;
		t_override;
		t_subclass;
		t_scramble;
		t_sync_lmfc;
		give_verdict;
	end

	// About 2500 cycles expected
	initial
	begin
		#500us;
		err_total++;
		give_verdict;
	end
endmodule // serial_link_param_regs_tb_top

bind serial_link_param_regs serial_link_param_props serial_link_param_props_inst (.core_clk, .rst, .octetIn,
	.octetInValid, .octetOut, .octetOutValid, .linkSyncN, .sysrefPulse, .syncRequest, .lmfcCount, .lmfcBoundary,
	.frameBoundary, .laneMode, .octetsPerFrame, .framesPerMultiframe, .scrambleOn, .subclass,
	.multiframe_clk_reset_ignore);
